// File: src/iepb_bank.sv
/*
 * iepb_bank: enable and priority register bank with gated request outputs,
 * sticky request status, mask and one level interrupt.
 * assumes flags arrive from peripheral logic on REF_CLK_I (no synchroniser),
 * and a local bus master that never strobes read and write together.
 */
`timescale 1ns/1ps

module iepb_bank (
    // clock and reset
    input  wire logic                     REF_CLK_I,
    input  wire logic                     RSTN_I,
    // register bus
    input  wire logic [3:0]               ADDR_I,
    input  wire logic [15:0]              WDATA_I,
    input  wire logic                     WR_I,
    input  wire logic                     RD_I,
    output logic      [15:0]              RDATA_O,
    // peripheral flags
    input  wire iepb_pkg::iepb_gate_word_t GATE_FLAG_I,
    input  wire iepb_pkg::iepb_level_src_t LEVEL_SRC_I,
    // requests toward the processor
    output iepb_pkg::iepb_gate_word_t     GATE_REQ_O,
    output logic      [11:0]              LEVEL_REQ_O,
    output logic      [35:0]              LEVEL_O,
    // interrupt
    output logic                          IRQ_O
);

    logic [15:0] enable_2_reg;
    logic [15:0] enable_3_reg;
    logic [15:0] enable_4_reg;
    logic [15:0] level_0_reg;
    logic [15:0] level_1_reg;
    logic [15:0] level_2_reg;
    logic [15:0] status_reg;
    logic [15:0] mask_reg;
    logic [15:0] rdata_next;
    logic [11:0] level_req_next;
    logic [11:0] level_req_rise;
    logic [35:0] level_all;
    logic [15:0] status_next;

    // writable register update keeps only implemented bits
    function automatic logic [15:0] wr_impl(input logic [15:0] data, input logic [15:0] impl);
        wr_impl = data & impl;
    endfunction

    // level field k of a priority word
    function automatic logic [2:0] field_of(input logic [15:0] word, input int k);
        field_of = word[k*iepb_pkg::LVL_STRIDE +: iepb_pkg::LVL_W];
    endfunction

    wire wr_hit = WR_I;

    // enable registers
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            enable_2_reg <= iepb_pkg::RST_ENABLE;
            enable_3_reg <= iepb_pkg::RST_ENABLE;
            enable_4_reg <= iepb_pkg::RST_ENABLE;
        end else if (wr_hit) begin
            if (ADDR_I == iepb_pkg::IDX_ENABLE_2) begin
                enable_2_reg <= wr_impl(WDATA_I, iepb_pkg::IMPL_ENABLE_2);
            end
            if (ADDR_I == iepb_pkg::IDX_ENABLE_3) begin
                enable_3_reg <= wr_impl(WDATA_I, iepb_pkg::IMPL_ENABLE_3);
            end
            if (ADDR_I == iepb_pkg::IDX_ENABLE_4) begin
                enable_4_reg <= wr_impl(WDATA_I, iepb_pkg::IMPL_ENABLE_4);
            end
        end
    end

    // priority registers
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            level_0_reg <= iepb_pkg::RST_LEVEL;
            level_1_reg <= iepb_pkg::RST_LEVEL;
            level_2_reg <= iepb_pkg::RST_LEVEL;
        end else if (wr_hit) begin
            if (ADDR_I == iepb_pkg::IDX_LEVEL_0) begin
                level_0_reg <= wr_impl(WDATA_I, iepb_pkg::IMPL_LEVEL);
            end
            if (ADDR_I == iepb_pkg::IDX_LEVEL_1) begin
                level_1_reg <= wr_impl(WDATA_I, iepb_pkg::IMPL_LEVEL);
            end
            if (ADDR_I == iepb_pkg::IDX_LEVEL_2) begin
                level_2_reg <= wr_impl(WDATA_I, iepb_pkg::IMPL_LEVEL);
            end
        end
    end

    // source k of word w sits at index 4w+k; field code is the level itself
    always_comb begin
        for (int k = 0; k < iepb_pkg::LVL_PER_WORD; k++) begin
            level_all[k*3 +: 3]      = field_of(level_0_reg, k);
            level_all[(k+4)*3 +: 3]  = field_of(level_1_reg, k);
            level_all[(k+8)*3 +: 3]  = field_of(level_2_reg, k);
        end
    end

    // a zero level kills the source even with its enable set
    always_comb begin
        for (int s = 0; s < iepb_pkg::NUM_LVL_SRC; s++) begin
            level_req_next[s] = LEVEL_SRC_I.flag[s] & LEVEL_SRC_I.enable[s]
                              & (level_all[s*3 +: 3] != iepb_pkg::LVL_OFF);
        end
    end

    // flags are only read, never altered here, so masking cannot lose them
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            GATE_REQ_O  <= '0;
            LEVEL_REQ_O <= '0;
            LEVEL_O     <= {12{3'h4}};
        end else begin
            GATE_REQ_O.word_2 <= GATE_FLAG_I.word_2 & enable_2_reg;
            GATE_REQ_O.word_3 <= GATE_FLAG_I.word_3 & enable_3_reg;
            GATE_REQ_O.word_4 <= GATE_FLAG_I.word_4 & enable_4_reg;
            LEVEL_REQ_O       <= level_req_next;
            LEVEL_O           <= level_all;
        end
    end

    // status: rising presented request sets, write-one clears, set wins
    assign level_req_rise = level_req_next & ~LEVEL_REQ_O;

    always_comb begin
        status_next = status_reg;
        if (wr_hit && ADDR_I == iepb_pkg::IDX_STATUS) begin
            status_next = status_next & ~WDATA_I;
        end
        status_next = (status_next | {4'h0, level_req_rise}) & iepb_pkg::IMPL_STATUS;
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            status_reg <= iepb_pkg::RST_STATUS;
        end else begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mask_reg <= iepb_pkg::RST_STATUS;
        end else if (wr_hit && ADDR_I == iepb_pkg::IDX_MASK) begin
            mask_reg <= wr_impl(WDATA_I, iepb_pkg::IMPL_STATUS);
        end
    end

    assign IRQ_O = |(status_reg & mask_reg);

    // read mux; unmapped indices answer zero
    always_comb begin
        case (ADDR_I)
            iepb_pkg::IDX_ENABLE_2: rdata_next = enable_2_reg;
            iepb_pkg::IDX_ENABLE_3: rdata_next = enable_3_reg;
            iepb_pkg::IDX_ENABLE_4: rdata_next = enable_4_reg;
            iepb_pkg::IDX_LEVEL_0:  rdata_next = level_0_reg;
            iepb_pkg::IDX_LEVEL_1:  rdata_next = level_1_reg;
            iepb_pkg::IDX_LEVEL_2:  rdata_next = level_2_reg;
            iepb_pkg::IDX_STATUS:   rdata_next = status_reg;
            iepb_pkg::IDX_MASK:     rdata_next = mask_reg;
            default:                rdata_next = 16'h0000;
        endcase
    end

    // read data stands one cycle only, zero otherwise
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            RDATA_O <= 16'h0000;
        end else if (RD_I) begin
            RDATA_O <= rdata_next;
        end else begin
            RDATA_O <= 16'h0000;
        end
    end

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    a_gate_blocks: assert property (
        (enable_3_reg == 16'h0000) |=> (GATE_REQ_O.word_3 == 16'h0000))
        else $error("request passed with all enables clear");

    a_gate_passes: assert property (
        $past(GATE_FLAG_I.word_4 & enable_4_reg) != 16'h0000 |-> GATE_REQ_O.word_4 != 16'h0000)
        else $error("enabled flag did not reach request");

    a_enable_rw: assert property (
        (WR_I && ADDR_I == iepb_pkg::IDX_ENABLE_3)
        |=> enable_3_reg == ($past(WDATA_I) & 16'hA7FF))
        else $error("enable write not stored");

    a_impl_zero: assert property (
        (enable_4_reg[15:8] == 8'h00) && !enable_4_reg[3] && !enable_3_reg[14]
        && (enable_3_reg[12:11] == 2'b00))
        else $error("unimplemented enable bit set");

    a_level_holes: assert property (
        ((level_0_reg | level_1_reg | level_2_reg) & 16'h8888) == 16'h0000)
        else $error("unimplemented level bit set");

    a_level_zero_off: assert property (
        (level_2_reg[14:12] == 3'h0) |=> !LEVEL_REQ_O[11])
        else $error("disabled source presented a request");

    a_level_present: assert property (
        (LEVEL_SRC_I.flag[0] && LEVEL_SRC_I.enable[0] && level_0_reg[2:0] != 3'h0)
        |=> LEVEL_REQ_O[0])
        else $error("qualified request not presented");

    a_level_map: assert property (
        ##1 LEVEL_O[11:9] == $past(level_0_reg[14:12]))
        else $error("level field mapping wrong");

    a_status_set: assert property (
        (level_req_next[4] && !LEVEL_REQ_O[4]) |=> status_reg[4] && (!mask_reg[4] || IRQ_O))
        else $error("status bit missed a request");

    a_read_one: assert property (
        (RD_I && ADDR_I == iepb_pkg::IDX_LEVEL_1) ##1 !RD_I |=> RDATA_O == 16'h0000)
        else $error("read data stood too long");

    a_gate2_blocks: assert property (
        (enable_2_reg == 16'h0000) |=> (GATE_REQ_O.word_2 == 16'h0000))
        else $error("word 2 request passed with enables clear");

    a_gate4_blocks: assert property (
        (enable_4_reg == 16'h0000) |=> (GATE_REQ_O.word_4 == 16'h0000))
        else $error("word 4 request passed with enables clear");

    a_gate2_exact: assert property (
        ##1 GATE_REQ_O.word_2 == $past(GATE_FLAG_I.word_2 & enable_2_reg))
        else $error("word 2 request differs from flag and enable");

    a_gate3_exact: assert property (
        ##1 GATE_REQ_O.word_3 == $past(GATE_FLAG_I.word_3 & enable_3_reg))
        else $error("word 3 request differs from flag and enable");

    a_gate4_exact: assert property (
        ##1 GATE_REQ_O.word_4 == $past(GATE_FLAG_I.word_4 & enable_4_reg))
        else $error("word 4 request differs from flag and enable");

    a_enable2_rw: assert property (
        (WR_I && ADDR_I == iepb_pkg::IDX_ENABLE_2)
        |=> enable_2_reg == ($past(WDATA_I) & iepb_pkg::IMPL_ENABLE_2))
        else $error("enable word 2 write not stored");

    a_enable4_rw: assert property (
        (WR_I && ADDR_I == iepb_pkg::IDX_ENABLE_4)
        |=> enable_4_reg == ($past(WDATA_I) & iepb_pkg::IMPL_ENABLE_4))
        else $error("enable word 4 write not stored");

    a_level0_rw: assert property (
        (WR_I && ADDR_I == iepb_pkg::IDX_LEVEL_0)
        |=> level_0_reg == ($past(WDATA_I) & iepb_pkg::IMPL_LEVEL))
        else $error("level word 0 write not stored");

    a_level1_rw: assert property (
        (WR_I && ADDR_I == iepb_pkg::IDX_LEVEL_1)
        |=> level_1_reg == ($past(WDATA_I) & iepb_pkg::IMPL_LEVEL))
        else $error("level word 1 write not stored");

    a_level2_rw: assert property (
        (WR_I && ADDR_I == iepb_pkg::IDX_LEVEL_2)
        |=> level_2_reg == ($past(WDATA_I) & iepb_pkg::IMPL_LEVEL))
        else $error("level word 2 write not stored");

    a_enable_hold: assert property (
        !(WR_I && ADDR_I == iepb_pkg::IDX_ENABLE_3) |=> $stable(enable_3_reg))
        else $error("enable word 3 changed without a write");

    a_level_hold: assert property (
        !(WR_I && ADDR_I == iepb_pkg::IDX_LEVEL_0) |=> $stable(level_0_reg))
        else $error("level word 0 changed without a write");

    a_enable2_holes: assert property (
        (enable_2_reg & ~iepb_pkg::IMPL_ENABLE_2) == 16'h0000)
        else $error("unimplemented enable word 2 bit set");

    a_level_map0: assert property (
        ##1 LEVEL_O[2:0] == $past(level_0_reg[2:0]))
        else $error("external irq 0 level mapped wrong");

    a_level_map1: assert property (
        ##1 LEVEL_O[23:21] == $past(level_1_reg[14:12]))
        else $error("timer2 level mapped wrong");

    a_level_dma0: assert property (
        ##1 LEVEL_O[14:12] == $past(level_1_reg[2:0]))
        else $error("dma ch0 level mapped wrong");

    a_level_map2: assert property (
        ##1 LEVEL_O[35:33] == $past(level_2_reg[14:12]))
        else $error("uart a rx level mapped wrong");

    a_level_spi: assert property (
        ##1 LEVEL_O[29:27] == $past(level_2_reg[6:4]))
        else $error("spi a error level mapped wrong");

    a_kill_ext0: assert property (
        (level_0_reg[2:0] == 3'h0) |=> !LEVEL_REQ_O[0])
        else $error("disabled external irq 0 presented");

    a_kill_dma0: assert property (
        (level_1_reg[2:0] == 3'h0) |=> !LEVEL_REQ_O[4])
        else $error("disabled dma ch0 presented");

    a_req_flag: assert property (
        !LEVEL_SRC_I.flag[7] |=> !LEVEL_REQ_O[7])
        else $error("request presented without a flag");

    a_req_enable: assert property (
        !LEVEL_SRC_I.enable[8] |=> !LEVEL_REQ_O[8])
        else $error("request presented without an enable");

    a_req_exact: assert property (
        ##1 LEVEL_REQ_O == $past(level_req_next))
        else $error("presented requests lag or lead");

    a_status_sticky: assert property (
        (status_reg[0] && !(WR_I && ADDR_I == iepb_pkg::IDX_STATUS && WDATA_I[0])) |=> status_reg[0])
        else $error("status bit dropped without a clear");

    a_status_clear: assert property (
        (WR_I && ADDR_I == iepb_pkg::IDX_STATUS && WDATA_I[1] && !level_req_rise[1]) |=> !status_reg[1])
        else $error("status bit survived its clear");

    a_status_holes: assert property (
        (status_reg[15:12] == 4'h0) && (mask_reg[15:12] == 4'h0))
        else $error("unimplemented status or mask bit set");

    a_irq_masked: assert property (
        (mask_reg == 16'h0000) |-> !IRQ_O)
        else $error("interrupt raised with mask clear");

    a_read_enable4: assert property (
        (RD_I && ADDR_I == iepb_pkg::IDX_ENABLE_4) |=> (RDATA_O[15:8] == 8'h00) && !RDATA_O[3])
        else $error("unimplemented enable bit read as one");

    a_read_level: assert property (
        (RD_I && ADDR_I == iepb_pkg::IDX_LEVEL_2) |=> (RDATA_O & ~iepb_pkg::IMPL_LEVEL) == 16'h0000)
        else $error("unimplemented level bit read as one");

    a_read_unmapped: assert property (
        (RD_I && ADDR_I[3]) |=> RDATA_O == 16'h0000)
        else $error("unmapped index read nonzero");

    a_read_value: assert property (
        (RD_I && ADDR_I == iepb_pkg::IDX_ENABLE_2) |=> RDATA_O == $past(enable_2_reg))
        else $error("enable word 2 read back wrong");

    a_enable_clear: assert property (
        (WR_I && ADDR_I == iepb_pkg::IDX_ENABLE_4 && !WDATA_I[0]) |=> ##1 !GATE_REQ_O.word_4[0])
        else $error("cleared enable still passed fault b");

    c_irq_raised:  cover property (!IRQ_O ##1 IRQ_O);
    c_level_kill:  cover property (LEVEL_SRC_I.flag[3] && LEVEL_SRC_I.enable[3] && level_0_reg[14:12] == 3'h0);
    c_gate_toggle: cover property (enable_2_reg[0] ##1 !enable_2_reg[0] && GATE_FLAG_I.word_2[0]);
    c_status_clr:  cover property (WR_I && ADDR_I == iepb_pkg::IDX_STATUS && status_reg != 16'h0000);
    c_read_back:   cover property (RD_I ##1 RDATA_O != 16'h0000);

endmodule

// File: src/iepb_pkg.sv
/*
 * iepb_pkg: register map, field layout, reset values and carrier types of the
 * interrupt enable and priority bank.
 * assumes one 200 MHz clock domain shared with the peripherals and the cpu.
 */
package iepb_pkg;

    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 16;
    localparam int          LVL_W         = 3;
    localparam int          NUM_LVL_SRC   = 12;

    // register indices on the local bus
    localparam logic [3:0]  IDX_ENABLE_2  = 4'h0;
    localparam logic [3:0]  IDX_ENABLE_3  = 4'h1;
    localparam logic [3:0]  IDX_ENABLE_4  = 4'h2;
    localparam logic [3:0]  IDX_LEVEL_0   = 4'h3;
    localparam logic [3:0]  IDX_LEVEL_1   = 4'h4;
    localparam logic [3:0]  IDX_LEVEL_2   = 4'h5;
    localparam logic [3:0]  IDX_STATUS    = 4'h6;
    localparam logic [3:0]  IDX_MASK      = 4'h7;

    // implemented bits of each register
    localparam logic [15:0] IMPL_ENABLE_2 = 16'h0007;
    localparam logic [15:0] IMPL_ENABLE_3 = 16'hA7FF;
    localparam logic [15:0] IMPL_ENABLE_4 = 16'h00F7;
    localparam logic [15:0] IMPL_LEVEL    = 16'h7777;
    localparam logic [15:0] IMPL_STATUS   = 16'h0FFF;

    // reset values
    localparam logic [15:0] RST_ENABLE    = 16'h0000;
    localparam logic [15:0] RST_LEVEL     = 16'h4444;
    localparam logic [15:0] RST_STATUS    = 16'h0000;

    // field positions: a level field k sits at bits 4k+2..4k
    localparam int          LVL_STRIDE    = 4;
    localparam int          LVL_PER_WORD  = 4;
    localparam logic [2:0]  LVL_OFF       = 3'h0;

    // flag words laid out like the enable registers they are gated by
    typedef struct packed {
        logic [15:0] word_4;
        logic [15:0] word_3;
        logic [15:0] word_2;
    } iepb_gate_word_t;

    // level-controlled sources: flag plus the enable held elsewhere
    typedef struct packed {
        logic [NUM_LVL_SRC-1:0] flag;
        logic [NUM_LVL_SRC-1:0] enable;
    } iepb_level_src_t;

endpackage

// File: tb/test_iepb_bank.sv
/*
 * test_iepb_bank: self-checking bench for the enable and priority bank.
 * assumes the register map and reset values of iepb_pkg and a bus master
 * that strobes one cycle at a time; the bench stands in for peripherals.
 */
`timescale 1ns/1ps

module test_iepb_bank;
    logic                      ref_clk;
    logic                      rst_n;
    logic                      wr;
    logic                      rd;
    logic [3:0]                addr;
    logic [15:0]               wdata;
    logic [15:0]               rdata;
    logic [15:0]               d;
    iepb_pkg::iepb_gate_word_t gate_flag;
    iepb_pkg::iepb_gate_word_t gate_req;
    iepb_pkg::iepb_level_src_t level_src;
    logic [11:0]               level_req;
    logic [35:0]               level;
    logic                      irq;
    logic [47:0]               e;
    logic [35:0]               exp_lvl;
    logic [11:0]               exp_req;
    logic [2:0]                f;
    logic [15:0]               impl [9];
    logic [15:0]               rst_tab [9];
    logic [15:0]               lvl_w [3];
    int                        failures;
    int                        compares;

    iepb_bank i_iepb_bank (
        .REF_CLK_I   (ref_clk),
        .RSTN_I      (rst_n),
        .ADDR_I      (addr),
        .WDATA_I     (wdata),
        .WR_I        (wr),
        .RD_I        (rd),
        .RDATA_O     (rdata),
        .GATE_FLAG_I (gate_flag),
        .LEVEL_SRC_I (level_src),
        .GATE_REQ_O  (gate_req),
        .LEVEL_REQ_O (level_req),
        .LEVEL_O     (level),
        .IRQ_O       (irq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic report_and_stop;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 16'h0000;
        gate_flag = '0; level_src = '0; failures = 0; compares = 0;
        impl = '{iepb_pkg::IMPL_ENABLE_2, iepb_pkg::IMPL_ENABLE_3, iepb_pkg::IMPL_ENABLE_4,
                 iepb_pkg::IMPL_LEVEL, iepb_pkg::IMPL_LEVEL, iepb_pkg::IMPL_LEVEL,
                 16'h0FFF, 16'h0FFF, 16'h0000};
        rst_tab = '{16'h0000, 16'h0000, 16'h0000, 16'h4444, 16'h4444, 16'h4444,
                    16'h0000, 16'h0000, 16'h0000};
        lvl_w = '{16'hF310, 16'h2465, 16'h0777};
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 9; a++) begin
            rd_reg(a[3:0], d);
            chk(48'(d), 48'(rst_tab[a]));
        end
        @(posedge ref_clk);
        #1;
        chk(48'(rdata), 48'h0);
        chk(48'(level), 48'({12{3'h4}}));
        $display("test reset values done");
        // status is write-one-to-clear, so it reads back empty
        for (int a = 0; a < 9; a++) begin
            wr_reg(a[3:0], 16'hFFFF);
            rd_reg(a[3:0], d);
            chk(48'(d), (a == 6) ? 48'h0 : 48'(impl[a]));
        end
        settle();
        chk(48'(level), 48'({12{3'h7}}));
        $display("test read back masks done");
        @(posedge ref_clk);
        gate_flag <= '1;
        for (int w = 0; w < 3; w++) begin
            wr_reg(w[3:0], 16'h0000);
        end
        // one enable bit at a time so a swapped position shows up
        for (int w = 0; w < 3; w++) begin
            for (int b = 0; b < 16; b++) begin
                wr_reg(w[3:0], 16'h0001 << b);
                settle();
                e = 48'(impl[w] & (16'h0001 << b)) << (16 * w);
                chk(gate_req, e);
            end
            wr_reg(w[3:0], 16'h0000);
        end
        settle();
        chk(gate_req, 48'h0);
        @(posedge ref_clk);
        gate_flag <= '0;
        for (int w = 0; w < 3; w++) begin
            wr_reg(w[3:0], 16'hFFFF);
        end
        settle();
        chk(gate_req, 48'h0);
        $display("test gate enables done");
        for (int w = 0; w < 3; w++) begin
            wr_reg(4'(3 + w), lvl_w[w]);
        end
        @(posedge ref_clk);
        level_src <= {12'hFFF, 12'hFFF};
        settle();
        for (int s = 0; s < 12; s++) begin
            f = lvl_w[s / 4][4 * (s % 4) +: 3];
            exp_lvl[3 * s +: 3] = f;
            exp_req[s] = (f != 3'h0);
        end
        chk(48'(level), 48'(exp_lvl));
        chk(48'(level_req), 48'(exp_req));
        @(posedge ref_clk);
        level_src.enable <= 12'h000;
        settle();
        chk(48'(level_req), 48'h0);
        $display("test priority levels done");
        wr_reg(iepb_pkg::IDX_STATUS, 16'hFFFF);
        @(posedge ref_clk);
        level_src <= {12'h000, 12'hFFF};
        settle();
        level_src.flag <= 12'h008;
        settle();
        chk(48'(irq), 48'h1);
        rd_reg(iepb_pkg::IDX_STATUS, d);
        chk(48'(d), 48'h0008);
        wr_reg(iepb_pkg::IDX_MASK, 16'h0000);
        #1;
        chk(48'(irq), 48'h0);
        wr_reg(iepb_pkg::IDX_MASK, 16'hFFFF);
        #1;
        chk(48'(irq), 48'h1);
        wr_reg(iepb_pkg::IDX_STATUS, 16'h0008);
        #1;
        chk(48'(irq), 48'h0);
        chk(48'(level_req), 48'h008);
        $display("test interrupt status done");
        report_and_stop();
    end
endmodule
